// ### core/mfr_pkg.sv
// What this block does
// - Every channel owns an active-low partial reset that touches only that channel.
// - Partial reset zeroes that channel's read and write pointers and output register.
// - Partial reset keeps mode, widths, data rate and flag offsets as they were.
// - Four-channel mode splits the read bus into four 10-bit lanes, channel 0 lowest.
// - Two-channel mode gives channel 0 bits 19..0 and channel 2 bits 39..20.
// - Single rate reads one word per rising read clock with enable and select low.
// - Double rate reads a word on both read clock edges while reading is enabled.
// - Double rate samples enables at rising edges only; bursts always start rising.
// - Read select, taken at rising read clock, gates reads and the lane drivers.
// - During master or partial reset, select is ignored; lanes drive when enable low.
// - Double rate select is caught during master reset and applies to all channels.
// - Each rising serial clock with write enable low shifts one bit into offsets.
// - Read enable low copies offsets to a shifter, one bit out per rising edge.
// - A high output enable forces that channel's lanes to high impedance.
package mfr_pkg;
    localparam int MFR_NCH = 4;
    localparam int MFR_LANE_W = 10;
    localparam int MFR_WIDE_W = 20;
    localparam int MFR_BUS_W = 40;
    localparam int MFR_ADDR_W = 4;
    localparam int MFR_OFS_W = 16;
    localparam logic [15:0] MFR_OFS_RST = 16'h007f;
    localparam int MFR_BUF_N = 2;
    localparam int MFR_SYNC_N = 2;
endpackage

// ### core/mfr_mem.sv
`timescale 1ns/1ps
module mfr_mem #(
    parameter int DW = 20,
    parameter int AW = 4
) (
    // Clock
    input wire logic i_clk,
    // Write side
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    // Read side
    input wire logic i_re,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        if (i_re) begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

// ### core/mfr_read_port.sv
`timescale 1ns/1ps
module mfr_read_port import mfr_pkg::*; #(
    parameter int NCH = MFR_NCH,
    parameter int DW = MFR_WIDE_W,
    parameter int AW = MFR_ADDR_W,
    parameter int OFS_W = MFR_OFS_W
) (
    // Clock and master reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Straps caught during master reset
    input wire logic i_read_double_rate_sel,
    input wire logic i_dual_mode_sel,
    // Read port pins, one bit per channel, plus the shared 40-bit data bus and its lane enables
    input wire logic [NCH-1:0] i_rd_clk,
    input wire logic [NCH-1:0] i_rd_en_n,
    input wire logic [NCH-1:0] i_read_select_n,
    input wire logic [NCH-1:0] i_out_en_n,
    input wire logic [NCH-1:0] i_channel_partial_reset_n,
    output logic [MFR_BUS_W-1:0] o_q,
    output logic [MFR_BUS_W-1:0] o_q_oe,
    // Word handshake behind the output register
    output logic [NCH-1:0] o_q_valid,
    input wire logic [NCH-1:0] i_q_ready,
    // Write side of the shared pointers, same clock
    input wire logic [NCH-1:0] i_wr_valid,
    input wire logic [NCH-1:0][DW-1:0] i_wr_data,
    output logic [NCH-1:0] o_wr_full,
    // Offset serial port
    input wire logic i_offset_serial_clk,
    input wire logic i_offset_serial_write_en_n,
    input wire logic i_offset_serial_read_en_n,
    input wire logic i_fallthrough_sel_serial_in,
    output logic o_offset_serial_out,
    output logic [NCH*2*OFS_W-1:0] o_flag_offsets
);
    localparam int OFS_N = NCH * 2 * OFS_W;

    typedef struct packed {
        logic [NCH-1:0][2:0] rclk_s;
        logic [NCH-1:0][1:0] ren_s;
        logic [NCH-1:0][1:0] rsel_s;
        logic [NCH-1:0][1:0] prst_s;
        logic [NCH-1:0][1:0] oe_s;
        logic [2:0] sclk_s;
        logic [1:0] swr_s;
        logic [2:0] srd_s;
        logic [1:0] si_s;
        logic [1:0] dbl_s;
        logic [1:0] dual_s;
        logic ddr;
        logic dual;
        logic [NCH-1:0] rsel_q;
        logic [NCH-1:0][AW:0] wptr;
        logic [NCH-1:0][AW:0] rptr;
        logic [NCH-1:0] pend;
        logic [NCH-1:0] mrd;
        logic [NCH-1:0][MFR_BUF_N-1:0][DW-1:0] fbuf;
        logic [NCH-1:0][1:0] bcnt;
        logic [NCH-1:0][DW-1:0] outq;
        logic [MFR_BUS_W-1:0] q;
        logic [NCH-1:0] qv;
        logic [NCH-1:0] lane_oe;
        logic [NCH-1:0] full;
        logic [OFS_N-1:0] ofs;
        logic [OFS_N-1:0] sh;
        logic offset_serial_out;
    } mfr_state_t;

    mfr_state_t s_r;
    mfr_state_t s_nxt;
    logic [NCH-1:0] rd_go;
    logic [NCH-1:0][DW-1:0] mem_q;
    logic [NCH-1:0] wr_go;

    // A read is only issued when the two-entry buffer can take the word, so a stalled
    // receiver makes the FIFO hold data instead of dropping it.
    function automatic logic has_room(input logic [1:0] cnt, input logic inflight);
        return ({1'b0, cnt} + {2'b00, inflight}) < 3'(MFR_BUF_N);
    endfunction

    function automatic logic ptr_empty(input logic [AW:0] wp, input logic [AW:0] rp);
        return wp == rp;
    endfunction

    function automatic logic ptr_full(input logic [AW:0] wp, input logic [AW:0] rp);
        return (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    endfunction

    for (genvar c = 0; c < NCH; c++) begin : g_mem
        mfr_mem #(.DW(DW), .AW(AW)) u_mem (
            .i_clk(i_clk),
            .i_we(wr_go[c]),
            .i_waddr(s_r.wptr[c][AW-1:0]),
            .i_wdata(i_wr_data[c]),
            .i_re(rd_go[c]),
            .i_raddr(s_r.rptr[c][AW-1:0]),
            .o_rdata(mem_q[c])
        );
    end

    always_comb begin
        logic rise;
        logic fall;
        logic prst;
        logic ok;
        logic [1:0] cnt;
        logic [NCH-1:0] oe_l;
        s_nxt = s_r;
        rise = 1'b0;
        fall = 1'b0;
        prst = 1'b0;
        ok = 1'b0;
        cnt = 2'h0;
        oe_l = '0;
        rd_go = '0;
        wr_go = '0;
        for (int c = 0; c < NCH; c++) begin
            s_nxt.rclk_s[c] = {s_r.rclk_s[c][1:0], i_rd_clk[c]};
            s_nxt.ren_s[c] = {s_r.ren_s[c][0], i_rd_en_n[c]};
            s_nxt.rsel_s[c] = {s_r.rsel_s[c][0], i_read_select_n[c]};
            s_nxt.prst_s[c] = {s_r.prst_s[c][0], i_channel_partial_reset_n[c]};
            s_nxt.oe_s[c] = {s_r.oe_s[c][0], i_out_en_n[c]};
            rise = s_r.rclk_s[c][1] & ~s_r.rclk_s[c][2];
            fall = ~s_r.rclk_s[c][1] & s_r.rclk_s[c][2];
            prst = ~s_r.prst_s[c][1];
            ok = !ptr_empty(s_r.wptr[c], s_r.rptr[c]) && has_room(s_r.bcnt[c], s_r.mrd[c])
                && !prst;
            if (rise) begin
                s_nxt.rsel_q[c] = s_r.rsel_s[c][1];
                if (!s_r.ren_s[c][1] && !s_r.rsel_s[c][1]) begin
                    rd_go[c] = ok;
                    s_nxt.pend[c] = s_r.ddr;
                end else begin
                    s_nxt.pend[c] = 1'b0;
                end
            end else if (fall && s_r.pend[c]) begin
                // An underrun on the falling half simply skips that word.
                rd_go[c] = ok;
                s_nxt.pend[c] = 1'b0;
            end
            wr_go[c] = i_wr_valid[c] && !s_r.full[c] && !prst;
            if (wr_go[c]) begin
                s_nxt.wptr[c] = s_r.wptr[c] + 1'b1;
            end
            if (rd_go[c]) begin
                s_nxt.rptr[c] = s_r.rptr[c] + 1'b1;
            end
            s_nxt.mrd[c] = rd_go[c];
            cnt = s_r.bcnt[c];
            if (s_r.qv[c] && i_q_ready[c]) begin
                s_nxt.qv[c] = 1'b0;
            end
            if (cnt != 2'h0 && (!s_r.qv[c] || i_q_ready[c])) begin
                s_nxt.outq[c] = s_r.fbuf[c][0];
                s_nxt.qv[c] = 1'b1;
                s_nxt.fbuf[c][0] = s_r.fbuf[c][1];
                cnt = cnt - 2'h1;
            end
            if (s_r.mrd[c]) begin
                s_nxt.fbuf[c][cnt[0]] = mem_q[c];
                cnt = cnt + 2'h1;
            end
            s_nxt.bcnt[c] = cnt;
            if (prst) begin
                s_nxt.wptr[c] = '0;
                s_nxt.rptr[c] = '0;
                s_nxt.outq[c] = '0;
                s_nxt.qv[c] = 1'b0;
                s_nxt.bcnt[c] = 2'h0;
                s_nxt.pend[c] = 1'b0;
                s_nxt.mrd[c] = 1'b0;
            end
            s_nxt.full[c] = ptr_full(s_nxt.wptr[c], s_nxt.rptr[c]);
            oe_l[c] = ~s_r.oe_s[c][1] & (prst | i_rst | ~s_nxt.rsel_q[c]);
        end
        for (int c = 0; c < NCH; c += 2) begin
            s_nxt.lane_oe[c] = oe_l[c];
            s_nxt.lane_oe[c+1] = s_r.dual ? oe_l[c] : oe_l[c+1];
            if (s_r.dual) begin
                s_nxt.q[c*MFR_LANE_W +: MFR_WIDE_W] = s_nxt.outq[c][MFR_WIDE_W-1:0];
            end else begin
                s_nxt.q[c*MFR_LANE_W +: MFR_LANE_W] = s_nxt.outq[c][MFR_LANE_W-1:0];
                s_nxt.q[(c+1)*MFR_LANE_W +: MFR_LANE_W] = s_nxt.outq[c+1][MFR_LANE_W-1:0];
            end
        end
        s_nxt.sclk_s = {s_r.sclk_s[1:0], i_offset_serial_clk};
        s_nxt.swr_s = {s_r.swr_s[0], i_offset_serial_write_en_n};
        s_nxt.srd_s = {s_r.srd_s[1:0], i_offset_serial_read_en_n};
        s_nxt.si_s = {s_r.si_s[0], i_fallthrough_sel_serial_in};
        s_nxt.dbl_s = {s_r.dbl_s[0], i_read_double_rate_sel};
        s_nxt.dual_s = {s_r.dual_s[0], i_dual_mode_sel};
        if (!s_r.srd_s[1] && s_r.srd_s[2]) begin
            s_nxt.sh = s_r.ofs;
        end
        if (s_r.sclk_s[1] && !s_r.sclk_s[2]) begin
            if (!s_r.swr_s[1]) begin
                s_nxt.ofs = {s_r.ofs[OFS_N-2:0], s_r.si_s[1]};
            end
            if (!s_r.srd_s[1]) begin
                s_nxt.offset_serial_out = s_nxt.sh[OFS_N-1];
                s_nxt.sh = {s_nxt.sh[OFS_N-2:0], 1'b0};
            end
        end
        if (i_rst) begin
            s_nxt.ddr = s_r.dbl_s[1];
            s_nxt.dual = s_r.dual_s[1];
            s_nxt.wptr = '0;
            s_nxt.rptr = '0;
            s_nxt.pend = '0;
            s_nxt.mrd = '0;
            s_nxt.bcnt = '0;
            s_nxt.outq = '0;
            s_nxt.q = '0;
            s_nxt.qv = '0;
            s_nxt.full = '0;
            s_nxt.rsel_q = '1;
            s_nxt.ofs = {(NCH * 2){MFR_OFS_RST[OFS_W-1:0]}};
            s_nxt.sh = '0;
            s_nxt.offset_serial_out = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        s_r <= s_nxt;
    end

    // The lane mux sits before the flops, so the data pins never glitch on the mode decode.
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            o_q_oe[c*MFR_LANE_W +: MFR_LANE_W] = {MFR_LANE_W{s_r.lane_oe[c]}};
        end
    end

    assign o_q = s_r.q;
    assign o_q_valid = s_r.qv;
    assign o_wr_full = s_r.full;
    assign o_offset_serial_out = s_r.offset_serial_out;
    assign o_flag_offsets = s_r.ofs;

    for (genvar c = 0; c < NCH; c++) begin : g_chk
        prst_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
            !s_r.prst_s[c][1] |=> (s_r.rptr[c] == '0 && s_r.wptr[c] == '0 && s_r.outq[c] == '0))
            else $error("partial reset did not clear channel");
        sdr_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
            (!s_r.ddr && s_r.rclk_s[c][1] && !s_r.rclk_s[c][2] && !s_r.ren_s[c][1]
             && !s_r.rsel_s[c][1] && s_r.prst_s[c][1] && s_r.wptr[c] != s_r.rptr[c]
             && s_r.bcnt[c] == 2'h0 && !s_r.mrd[c])
            |=> s_r.rptr[c] == $past(s_r.rptr[c]) + 1'b1 ##1 s_r.bcnt[c] != 2'h0 || s_r.qv[c])
            else $error("single rate read did not advance");
        no_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
            (s_r.rclk_s[c][1] && !s_r.rclk_s[c][2] && (s_r.ren_s[c][1] || s_r.rsel_s[c][1])
             && s_r.prst_s[c][1]) |=> $stable(s_r.rptr[c]) ##1 $stable(s_r.rptr[c]))
            else $error("read happened while disabled");
        ddr_fall_a: assert property (@(posedge i_clk) disable iff (i_rst)
            (s_r.pend[c] && !s_r.rclk_s[c][1] && s_r.rclk_s[c][2] && s_r.prst_s[c][1]
             && s_r.wptr[c] != s_r.rptr[c] && s_r.bcnt[c] == 2'h0 && !s_r.mrd[c])
            |=> s_r.rptr[c] == $past(s_r.rptr[c]) + 1'b1)
            else $error("falling edge word missing in double rate");
        ddr_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
            (!s_r.pend[c] && !s_r.rclk_s[c][1] && s_r.rclk_s[c][2]) |=> $stable(s_r.rptr[c]))
            else $error("burst began on a falling edge");
        oe_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
            (s_r.oe_s[c][1] && !s_r.dual) |=> !s_r.lane_oe[c])
            else $error("lane driven while output enable high");
        rst_drive_a: assert property (@(posedge i_clk) disable iff (i_rst)
            (!s_r.prst_s[c][1] && !s_r.oe_s[c][1] && !s_r.dual) |=> s_r.lane_oe[c])
            else $error("lane not driven during partial reset");
        sel_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
            (s_r.prst_s[c][1] && !s_r.dual) |=> (!s_r.rsel_q[c] || !s_r.lane_oe[c]))
            else $error("lane driven while deselected");
        mode_kept_a: assert property (@(posedge i_clk) disable iff (i_rst)
            !s_r.prst_s[c][1] |=> ($stable(s_r.ddr) && $stable(s_r.dual)))
            else $error("partial reset changed the mode");
    end

    strap_catch_a: assert property (@(posedge i_clk)
        i_rst |=> s_r.ddr == $past(s_r.dbl_s[1]))
        else $error("double rate strap not caught");
    ser_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_r.sclk_s[1] && !s_r.sclk_s[2] && !s_r.swr_s[1])
        |=> s_r.ofs[0] == $past(s_r.si_s[1]) && s_r.ofs[OFS_N-1:1] == $past(s_r.ofs[OFS_N-2:0]))
        else $error("serial bit not shifted into offsets");
    ser_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_r.swr_s[1] && !s_r.srd_s[1]) |=> $stable(s_r.ofs))
        else $error("serial read altered offsets");
endmodule

// ### dv/mfr_rd_model.sv
`timescale 1ns/1ps
module mfr_rd_model import mfr_pkg::*; (
    // Clock
    input wire logic i_clk,
    // Read port pins toward the block
    output logic [MFR_NCH-1:0] o_rd_clk,
    output logic [MFR_NCH-1:0] o_rd_en_n,
    output logic [MFR_NCH-1:0] o_read_select_n
);
    // Idle channels sit tied off, which also keeps the unused pair quiet in two-channel mode.
    initial begin
        o_rd_clk = '0;
        o_rd_en_n = '1;
        o_read_select_n = '1;
    end

    // One read clock cycle; the clock stands still low outside it.
    // Enables drop together with the falling edge, since only the rising edge samples them.
    task automatic cycle(input int ch, input logic en);
        o_rd_en_n[ch] <= ~en;
        o_read_select_n[ch] <= ~en;
        repeat (2) @(posedge i_clk);
        o_rd_clk[ch] <= 1'b1;
        repeat (8) @(posedge i_clk);
        o_rd_en_n[ch] <= 1'b1;
        o_read_select_n[ch] <= 1'b1;
        o_rd_clk[ch] <= 1'b0;
        repeat (8) @(posedge i_clk);
    endtask
endmodule

// ### dv/multi_fifo_read_port_offset_serial_tb_top.sv
`timescale 1ns/1ps
module multi_fifo_read_port_offset_serial_tb_top;
    import mfr_pkg::*;
    localparam logic [127:0] OFS_PAT = 128'h0123456789abcdeffedcba9876543210;
    logic clk, rst, ddr_sel, dual_sel, sclk, offset_serial_write_en_n_n, offset_serial_read_en_n_n, si, offset_serial_out, so;
    logic [3:0] out_en_n, prst_n, q_ready, wr_valid, q_valid, wr_full;
    logic [3:0][19:0] wr_data;
    logic [39:0] q, q_oe;
    logic [127:0] ofs;
    wire [3:0] rd_clk, rd_en_n, rsel_n;
    int fail_count = 0;
    int n_compared = 0;

    mfr_read_port u_mfr_read_port (.i_clk(clk), .i_rst(rst), .i_read_double_rate_sel(ddr_sel),
        .i_dual_mode_sel(dual_sel), .i_rd_clk(rd_clk), .i_rd_en_n(rd_en_n),
        .i_read_select_n(rsel_n), .i_out_en_n(out_en_n), .i_channel_partial_reset_n(prst_n),
        .o_q(q), .o_q_oe(q_oe), .o_q_valid(q_valid), .i_q_ready(q_ready),
        .i_wr_valid(wr_valid), .i_wr_data(wr_data), .o_wr_full(wr_full),
        .i_offset_serial_clk(sclk), .i_offset_serial_write_en_n(offset_serial_write_en_n_n),
        .i_offset_serial_read_en_n(offset_serial_read_en_n_n), .i_fallthrough_sel_serial_in(si),
        .o_offset_serial_out(offset_serial_out), .o_flag_offsets(ofs));
    mfr_rd_model u_mfr_rd_model (.i_clk(clk), .o_rd_clk(rd_clk), .o_rd_en_n(rd_en_n),
        .o_read_select_n(rsel_n));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic test_done();
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic do_reset(input logic dual, input logic ddr);
        dual_sel <= dual;
        ddr_sel <= ddr;
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic wr(input int ch, input logic [19:0] d);
        wr_valid[ch] <= 1'b1;
        wr_data[ch] <= d;
        @(posedge clk);
        wr_valid[ch] <= 1'b0;
        @(posedge clk);
    endtask

    task automatic take(input int ch, input int lo, input logic [39:0] mask, input logic [39:0] e);
        repeat (3) @(posedge clk);
        chk(q_valid[ch] === 1'b1 && ((q >> lo) & mask) === e, "read word wrong");
        q_ready[ch] <= 1'b1;
        @(posedge clk);
        q_ready[ch] <= 1'b0;
        @(posedge clk);
    endtask

    // Serial bit: falling half samples the output left by the previous rise.
    task automatic sbit(input logic b);
        si <= b;
        sclk <= 1'b0;
        repeat (2) @(posedge clk);
        so = offset_serial_out;
        repeat (2) @(posedge clk);
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    task automatic t_quad();
        for (int ch = 0; ch < 4; ch++) begin
            wr(ch, 20'hfa000 + 20'h0c1 * (ch + 1));
            u_mfr_rd_model.cycle(ch, 1'b0);
            chk(q_valid[ch] === 1'b0, "read without enable");
            u_mfr_rd_model.cycle(ch, 1'b1);
            take(ch, ch * 10, 40'h3ff, 40'(10'(20'h0c1 * (ch + 1))));
        end
        chk(q_oe === {40{1'b1}}, "lanes not driven");
        out_en_n[2] <= 1'b1;
        repeat (5) @(posedge clk);
        chk(q_oe === 40'hffc00fffff, "lane not released");
        out_en_n[2] <= 1'b0;
    endtask

    task automatic t_full();
        for (int k = 0; k < 4; k++) wr(3, 20'h00200 + 20'(k));
        for (int k = 0; k < 4; k++) u_mfr_rd_model.cycle(3, 1'b1);
        for (int k = 0; k < 3; k++) take(3, 30, 40'h3ff, 40'h200 + 40'(k));
        repeat (3) @(posedge clk);
        chk(q_valid[3] === 1'b0, "refused word appeared");
        u_mfr_rd_model.cycle(3, 1'b1);
        take(3, 30, 40'h3ff, 40'h203);
        for (int k = 0; k < 15; k++) wr(3, 20'h00300 + 20'(k));
        chk(wr_full[3] === 1'b0, "full flag early");
        wr(3, 20'h0030f);
        chk(wr_full[3] === 1'b1, "full flag missing");
        prst_n[3] <= 1'b0;
        repeat (4) @(posedge clk);
        prst_n[3] <= 1'b1;
        repeat (4) @(posedge clk);
        chk(wr_full[3] === 1'b0, "partial reset kept full");
    endtask

    task automatic t_serial();
        chk(ofs === {8{MFR_OFS_RST}}, "offset reset value");
        offset_serial_write_en_n_n <= 1'b0;
        for (int i = 127; i >= 0; i--) sbit(OFS_PAT[i]);
        offset_serial_write_en_n_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(ofs === OFS_PAT, "offsets not written");
        offset_serial_read_en_n_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 129; i++) begin
            sbit(1'b0);
            if (i > 0) chk(so === OFS_PAT[128 - i], "serial read bit");
        end
        offset_serial_read_en_n_n <= 1'b1;
        chk(ofs === OFS_PAT, "read altered offsets");
    endtask

    task automatic t_prst();
        wr(0, 20'h00155);
        wr(1, 20'h002aa);
        u_mfr_rd_model.cycle(1, 1'b1);
        u_mfr_rd_model.cycle(1, 1'b0);
        chk(q_oe[19:10] === 10'h000, "lane driven while deselected");
        prst_n[1] <= 1'b0;
        repeat (8) @(posedge clk);
        chk(q[19:10] === 10'h000 && q_valid[1] === 1'b0, "partial reset clear");
        chk(q_oe[19:10] === 10'h3ff, "lane floats in reset");
        prst_n[1] <= 1'b1;
        repeat (4) @(posedge clk);
        chk(ofs === OFS_PAT, "offsets lost");
        u_mfr_rd_model.cycle(0, 1'b1);
        take(0, 0, 40'h3ff, 40'h155);
    endtask

    task automatic t_ddr();
        do_reset(1'b1, 1'b1);
        wr(0, 20'h5a3c1);
        wr(0, 20'h0f0f0);
        u_mfr_rd_model.cycle(0, 1'b1);
        take(0, 0, 40'hfffff, 40'h5a3c1);
        take(0, 0, 40'hfffff, 40'h0f0f0);
        wr(2, 20'hc3a5e);
        u_mfr_rd_model.cycle(2, 1'b1);
        take(2, 20, 40'hfffff, 40'hc3a5e);
        chk(q_oe === {40{1'b1}}, "dual lanes not driven");
    endtask

    initial begin
        rst = 1'b1;
        ddr_sel = 1'b0;
        dual_sel = 1'b0;
        out_en_n = '0;
        prst_n = '1;
        q_ready = '0;
        wr_valid = '0;
        wr_data = '0;
        sclk = 1'b1;
        offset_serial_write_en_n_n = 1'b1;
        offset_serial_read_en_n_n = 1'b1;
        si = 1'b0;
        so = 1'b0;
        do_reset(1'b0, 1'b0);
        t_quad();
        t_full();
        t_serial();
        t_prst();
        t_ddr();
        test_done();
    end

    // Whole run needs about 2600 cycles; the limit leaves ample room.
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        test_done();
    end
endmodule
